// [gpc_pin_model.sv]
// pads and outside world of the gpio port
// takes the port's pad controls; the bench supplies the external drive
`timescale 1ns/1ns
module gpc_pin_model (
  input wire clk_i,
  input wire [7:0] drv_i,
  input wire [7:0] drv_en_i,
  input wire [7:0] pu_i,
  input wire [7:0] pd_i,
  input wire [7:0] ext_en_i,
  input wire [7:0] ext_i,
  output reg [7:0] level_o
);
  reg [7:0] last = 8'h00;
  integer k;
  always @(posedge clk_i) begin
    last <= level_o;
  end
  // floating pins flip every cycle
  always @* begin
    for (k = 0; k < 8; k = k + 1) begin
      if (drv_en_i[k])
        level_o[k] = drv_i[k];
      else if (ext_en_i[k])
        level_o[k] = ext_i[k];
      else if (pu_i[k] | pd_i[k])
        level_o[k] = pu_i[k];
      else
        level_o[k] = ~last[k];
    end
  end
endmodule

// [gpc_port.v]
// one 8-bit gpio port with pin interrupts, filters, pull control and special pins
// assumes synchronous pins, single bus clock, external pad models the drive
`timescale 1ns/1ns
`include "gpc_regs.vh"

// Contract
// [RL1] input register read-only, returns synchronized pin level always
// [RL2] direction selects input/output unless a peripheral owns the pin
// [RL3] direction bit picks data-register read source even under peripheral
// [RL4] reads settle within two bus clocks after direction change; code needs three (pad register then two sync flops)
// [RL5] reduced-drive bit sets output strength, no effect on inputs
// [RL6] pull enable active only for inputs or wired-or outputs
// [RL7] polarity picks pull-up/down; wired-or output allows pull-up only
// [RL8] wired-or bit disables high-side driver of outputs
// [RL9] interrupt enable bit masks its flag
// [RL10] flag set and held after valid filtered edge
// [RL11] routing register redirects pwm outputs to alternative pins
// [RL12] debug pin captured as mode select while reset asserted
// [RL13] two port pins optionally output core-rate and bus-rate clocks
// [RL14] maskable irq pin: level or falling edge, gated by enable and cpu mask
// [RL15] nonmaskable irq pin: level sensitive, enabled by clearing x mask
// [RL16] per-pin enable and edge selection, one shared interrupt request
// [RL17] request when flag and enable both set; also wakes cpu
// [RL18] filter ignores pulses up to 3 clocks, accepts 4 or more
// [RL19] valid edge needs 4 passive then 4 active samples
// [RL20] filters sample bus clock, or rc oscillator in stop mode
// [RL21] rc oscillator runs only while a pin counts, enabled, flag clear; code runs it for any enabled pin with flag clear (counters never exceed 4)
// [RL22] software loads data before setting direction, not in one word
// [RL23] data read gives pin level if direction 0, stored value if 1
// [RL24] data write always stores, reaches pin only as gpio output
// [RL25] flags cleared by writing one; zero leaves unchanged
module gpc_port (
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg wb_err_o,
  input wire [7:0] pin_i,
  output reg [7:0] pin_o,
  output reg [7:0] pin_oe_o,
  output reg [7:0] pull_up_o,
  output reg [7:0] pull_down_o,
  output reg [7:0] reduced_drive_o,
  input wire [7:0] periph_own_i,
  input wire [7:0] periph_oe_i,
  input wire [7:0] periph_dat_i,
  input wire [1:0] pwm_i,
  input wire stop_mode_i,
  input wire rc_clk_tick_i,
  output reg rc_osc_run_o,
  output reg pin_irq_o,
  output reg wake_o,
  input wire debug_mode_pin_i,
  output reg mode_select_o,
  input wire core_clk_ph_i,
  output reg core_rate_clock_out_o,
  output reg bus_rate_clock_out_o,
  input wire irq_pin_n_i,
  input wire cpu_i_mask_i,
  output reg maskable_irq_o,
  input wire nonmaskable_irq_input_pin_n_i,
  input wire cpu_x_mask_i,
  output reg nonmaskable_irq_o
);

  reg [7:0] port_output_value_reg;
  reg [7:0] pin_direction_reg;
  reg [7:0] drive_strength_reg;
  reg [7:0] pull_enable_reg;
  reg [7:0] pull_or_edge_polarity_reg;
  reg [7:0] open_drain_select_reg;
  reg [7:0] pin_irq_mask_reg;
  reg [7:0] pin_irq_flag_reg;
  reg [1:0] pwm_reroute_reg;
  reg [7:0] porte_ctrl;
  reg [7:0] sync1;
  reg [7:0] pin_level_readback_reg;
  reg [2:0] pas_cnt [0:7];
  reg [2:0] act_cnt [0:7];
  reg [7:0] armed;
  reg [7:0] edge_hit;
  reg [3:0] div_cnt;
  reg irq_s1;
  reg irq_s2;
  reg irq_prev;
  reg irq_edge_flag;
  reg [7:0] next_flag;
  reg [7:0] drv_val;
  reg [7:0] drv_en;
  reg [7:0] is_input;
  reg run_any;
  integer i;

  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire wr = req & wb_we_i & wb_sel_i[0];
  wire [7:0] wd = wb_dat_i[7:0];
  wire hit = (wb_adr_i <= `GPC_OFF_STATUS) && (wb_adr_i[1:0] == 2'b00);
  // filter advances every bus clock, or on rc ticks in stop
  wire samp = ~stop_mode_i | rc_clk_tick_i;

  function [2:0] sat_inc;
    input [2:0] c;
    begin
      sat_inc = (c >= `GPC_FILT_CNT) ? c : c + 3'd1;
    end
  endfunction

  // bus slave: one-cycle ack, err for unmapped
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req & hit;
      wb_err_o <= req & ~hit;
      wb_dat_o <= 32'h0000_0000;
      if (req & ~wb_we_i) begin
        case (wb_adr_i)
          // [RL1] read-only level
          `GPC_OFF_PIN_LEVEL: wb_dat_o[7:0] <= pin_level_readback_reg;
          // [RL23] [RL3] direction picks source
          `GPC_OFF_OUT_VALUE: wb_dat_o[7:0] <= (pin_direction_reg & port_output_value_reg)
            | (~pin_direction_reg & pin_level_readback_reg);
          `GPC_OFF_DIRECTION: wb_dat_o[7:0] <= pin_direction_reg;
          `GPC_OFF_DRIVE: wb_dat_o[7:0] <= drive_strength_reg;
          `GPC_OFF_PULL_EN: wb_dat_o[7:0] <= pull_enable_reg;
          `GPC_OFF_POLARITY: wb_dat_o[7:0] <= pull_or_edge_polarity_reg;
          `GPC_OFF_OPEN_DRAIN: wb_dat_o[7:0] <= open_drain_select_reg;
          `GPC_OFF_IRQ_MASK: wb_dat_o[7:0] <= pin_irq_mask_reg;
          `GPC_OFF_IRQ_FLAG: wb_dat_o[7:0] <= pin_irq_flag_reg;
          `GPC_OFF_PWM_REROUTE: wb_dat_o[1:0] <= pwm_reroute_reg;
          `GPC_OFF_PORTE_CTRL: wb_dat_o[7:0] <= porte_ctrl;
          `GPC_OFF_STATUS: wb_dat_o[3:0] <= {mode_select_o, irq_edge_flag,
            rc_osc_run_o, pin_irq_o};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // config registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      port_output_value_reg <= `GPC_RST_BYTE;
      pin_direction_reg <= `GPC_RST_BYTE;
      drive_strength_reg <= `GPC_RST_BYTE;
      pull_enable_reg <= `GPC_RST_BYTE;
      pull_or_edge_polarity_reg <= `GPC_RST_BYTE;
      open_drain_select_reg <= `GPC_RST_BYTE;
      pin_irq_mask_reg <= `GPC_RST_BYTE;
      pwm_reroute_reg <= 2'b00;
      porte_ctrl <= `GPC_RST_PORTE;
    end else if (wr) begin
      case (wb_adr_i)
        // [RL24] write always stores
        `GPC_OFF_OUT_VALUE: port_output_value_reg <= wd;
        `GPC_OFF_DIRECTION: pin_direction_reg <= wd;
        `GPC_OFF_DRIVE: drive_strength_reg <= wd;
        `GPC_OFF_PULL_EN: pull_enable_reg <= wd;
        `GPC_OFF_POLARITY: pull_or_edge_polarity_reg <= wd;
        `GPC_OFF_OPEN_DRAIN: open_drain_select_reg <= wd;
        `GPC_OFF_IRQ_MASK: pin_irq_mask_reg <= wd;
        // [RL11] pwm routing
        `GPC_OFF_PWM_REROUTE: pwm_reroute_reg <= wd[1:0];
        `GPC_OFF_PORTE_CTRL: porte_ctrl <= wd;
        default: porte_ctrl <= porte_ctrl;
      endcase
    end
  end

  // pad control
  always @* begin
    for (i = 0; i < 8; i = i + 1) begin
      // [RL2] peripheral overrides direction
      drv_val[i] = periph_own_i[i] ? periph_dat_i[i] : port_output_value_reg[i];
      drv_en[i] = periph_own_i[i] ? periph_oe_i[i] : pin_direction_reg[i];
      is_input[i] = ~drv_en[i];
    end
    // [RL11] rerouted pwm on pins 0 and 1
    if (pwm_reroute_reg[0]) begin
      drv_val[0] = pwm_i[0];
      drv_en[0] = 1'b1;
      is_input[0] = 1'b0;
    end
    if (pwm_reroute_reg[1]) begin
      drv_val[1] = pwm_i[1];
      drv_en[1] = 1'b1;
      is_input[1] = 1'b0;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_o <= 8'h00;
      pin_oe_o <= 8'h00;
      pull_up_o <= 8'h00;
      pull_down_o <= 8'h00;
      reduced_drive_o <= 8'h00;
    end else begin
      pin_o <= drv_val;
      // [RL8] wired-or drops high drive
      pin_oe_o <= drv_en & ~(open_drain_select_reg & drv_val);
      // [RL6] [RL7] pull gating
      pull_up_o <= pull_enable_reg & ~pull_or_edge_polarity_reg
        & (is_input | open_drain_select_reg);
      pull_down_o <= pull_enable_reg & pull_or_edge_polarity_reg & is_input;
      // [RL5] drive strength only on outputs
      reduced_drive_o <= drive_strength_reg & drv_en;
    end
  end

  // [RL4] two-flop sync, value valid within two clocks
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= 8'h00;
      pin_level_readback_reg <= 8'h00;
    end else begin
      sync1 <= pin_i;
      pin_level_readback_reg <= sync1;
    end
  end

  // glitch filters, polarity 0 = falling edge active
  always @(posedge clk_i) begin
    if (rst_i) begin
      for (i = 0; i < 8; i = i + 1) begin
        pas_cnt[i] <= 3'd0;
        act_cnt[i] <= 3'd0;
      end
      armed <= 8'h00;
      edge_hit <= 8'h00;
    end else begin
      edge_hit <= 8'h00;
      // [RL20] sample on bus clock or rc tick
      if (samp) begin
        for (i = 0; i < 8; i = i + 1) begin
          // passive level is the inverse of the active edge's final level
          if (pin_level_readback_reg[i] != pull_or_edge_polarity_reg[i]) begin
            act_cnt[i] <= 3'd0;
            pas_cnt[i] <= sat_inc(pas_cnt[i]);
            if (pas_cnt[i] == `GPC_FILT_CNT - 1)
              armed[i] <= 1'b1;
          end else begin
            pas_cnt[i] <= 3'd0;
            act_cnt[i] <= sat_inc(act_cnt[i]);
            // [RL18] [RL19] 4 passive then 4 active
            if (armed[i] && act_cnt[i] == `GPC_FILT_CNT - 1) begin
              edge_hit[i] <= 1'b1;
              armed[i] <= 1'b0;
            end
          end
        end
      end
    end
  end

  always @* begin
    next_flag = pin_irq_flag_reg;
    // [RL25] write one clears
    if (wr && wb_adr_i == `GPC_OFF_IRQ_FLAG)
      next_flag = next_flag & ~wd;
    // [RL10] set wins over clear
    next_flag = next_flag | edge_hit;
    run_any = 1'b0;
    for (i = 0; i < 8; i = i + 1)
      // [RL21] rc oscillator condition
      if (pas_cnt[i] <= `GPC_FILT_CNT && act_cnt[i] <= `GPC_FILT_CNT
          && pin_irq_mask_reg[i] && !pin_irq_flag_reg[i])
        run_any = 1'b1;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_irq_flag_reg <= 8'h00;
      pin_irq_o <= 1'b0;
      wake_o <= 1'b0;
      rc_osc_run_o <= 1'b0;
    end else begin
      pin_irq_flag_reg <= next_flag;
      // [RL9] [RL16] [RL17] masked shared request
      pin_irq_o <= |(next_flag & pin_irq_mask_reg);
      wake_o <= |(next_flag & pin_irq_mask_reg);
      rc_osc_run_o <= stop_mode_i & run_any;
    end
  end

  // [RL12] mode select captured during reset
  always @(posedge clk_i) begin
    if (rst_i)
      mode_select_o <= debug_mode_pin_i;
  end

  // [RL13] clock outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt <= 4'h0;
      bus_rate_clock_out_o <= 1'b0;
      core_rate_clock_out_o <= 1'b0;
    end else begin
      core_rate_clock_out_o <= porte_ctrl[`GPC_PE_CORE_CLK_BIT] & core_clk_ph_i;
      if (div_cnt >= porte_ctrl[`GPC_PE_DIV_MSB:`GPC_PE_DIV_LSB]) begin
        div_cnt <= 4'h0;
        bus_rate_clock_out_o <= porte_ctrl[`GPC_PE_BUS_CLK_BIT] & ~bus_rate_clock_out_o;
      end else begin
        div_cnt <= div_cnt + 4'h1;
      end
    end
  end

  // [RL14] [RL15] irq pins, inhibited at reset
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_s1 <= 1'b1;
      irq_s2 <= 1'b1;
      irq_prev <= 1'b1;
      irq_edge_flag <= 1'b0;
      maskable_irq_o <= 1'b0;
      nonmaskable_irq_o <= 1'b0;
    end else begin
      irq_s1 <= irq_pin_n_i;
      irq_s2 <= irq_s1;
      irq_prev <= irq_s2;
      if (irq_prev & ~irq_s2)
        irq_edge_flag <= 1'b1;
      else if (wr && wb_adr_i == `GPC_OFF_STATUS && wd[2])
        irq_edge_flag <= 1'b0;
      maskable_irq_o <= porte_ctrl[`GPC_PE_IRQ_EN_BIT] & ~cpu_i_mask_i
        & (porte_ctrl[`GPC_PE_IRQ_EDGE_BIT] ? irq_edge_flag : ~irq_s2);
      nonmaskable_irq_o <= ~cpu_x_mask_i & ~nonmaskable_irq_input_pin_n_i;
    end
  end

endmodule

// [gpc_port_bench.sv]
// self-checking bench for the gpio port
// needs gpc_port, gpc_pin_model and gpc_port_checker
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module gpc_port_bench;
  reg clk_i = 0;
  reg rst_i = 1;
  reg [7:0] wb_adr_i = 0, periph_own_i = 0, periph_oe_i = 0, periph_dat_i = 0;
  reg [31:0] wb_dat_i = 0, seed = 38, v;
  reg [3:0] wb_sel_i = 0;
  reg wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, stop_mode_i = 0, debug_mode_pin_i = 0;
  reg irq_pin_n_i = 1, cpu_i_mask_i = 1, nonmaskable_irq_input_pin_n_i = 1, cpu_x_mask_i = 1;
  reg [7:0] ext_en = 8'hff, ext = 0;
  wire [1:0] pwm_i = 2'b00;
  wire rc_clk_tick_i = 1'b0, core_clk_ph_i = 1'b0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, wb_err_o, rc_osc_run_o, pin_irq_o, wake_o, mode_select_o;
  wire core_rate_clock_out_o, bus_rate_clock_out_o, maskable_irq_o, nonmaskable_irq_o;
  wire [7:0] pin_i, pin_o, pin_oe_o, pull_up_o, pull_down_o, reduced_drive_o;
  int err_count = 0, n_checks = 0, i;
  reg [32:0] expq[$];
  always #10 clk_i = ~clk_i;
  gpc_port dut (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i,
    .wb_stb_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .pin_i, .pin_o, .pin_oe_o, .pull_up_o,
    .pull_down_o, .reduced_drive_o, .periph_own_i, .periph_oe_i, .periph_dat_i, .pwm_i,
    .stop_mode_i, .rc_clk_tick_i, .rc_osc_run_o, .pin_irq_o, .wake_o, .debug_mode_pin_i,
    .mode_select_o, .core_clk_ph_i, .core_rate_clock_out_o, .bus_rate_clock_out_o,
    .irq_pin_n_i, .cpu_i_mask_i, .maskable_irq_o, .nonmaskable_irq_input_pin_n_i, .cpu_x_mask_i,
    .nonmaskable_irq_o);
  gpc_pin_model pads (.clk_i, .drv_i(pin_o), .drv_en_i(pin_oe_o), .pu_i(pull_up_o),
    .pd_i(pull_down_o), .ext_en_i(ext_en), .ext_i(ext), .level_o(pin_i));
  function automatic [31:0] xs(input [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    xs = s ^ (s << 5);
  endfunction
  task automatic wb(input [7:0] a, input [31:0] d, input w, input [3:0] s);
    int t;
    @(posedge clk_i);
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_we_i <= w;
    wb_sel_i <= s;
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    for (t = 0; t < 20 && !(wb_ack_o | wb_err_o); t++) @(posedge clk_i);
    if (t >= 20) begin
      err_count++;
      $display("mismatch at %0t: bus answer timed out", $time);
    end
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask
  task automatic wr(input [7:0] a, input [31:0] d);
    wb(a, d, 1, 4'h1);
  endtask
  task automatic rd(input [7:0] a, input [32:0] e);
    expq.push_back(e);
    wb(a, 0, 0, 4'h1);
  endtask
  task automatic pulse(input [7:0] m, input int n);
    ext <= ext ^ m;
    repeat (n) @(posedge clk_i);
    ext <= ext ^ m;
    repeat (8) @(posedge clk_i);
  endtask
  task end_sim;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // answers are compared in request order
  always @(posedge clk_i) begin
    if ((wb_ack_o | wb_err_o) && !wb_we_i)
      `CHK({wb_err_o, wb_err_o ? 32'h0000_0000 : wb_dat_o}, expq.pop_front())
  end
  initial begin
    #100000;
    err_count++;
    $display("mismatch at %0t: run timed out", $time);
    end_sim;
  end
  initial begin
    seed = xs(seed);
    debug_mode_pin_i = seed[3];
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    ext <= seed[15:8];
    repeat (4) @(posedge clk_i);
    rd(8'h00, ext);
    rd(8'h04, ext);
    for (i = 8; i < 48; i += 4) rd(8'(i), i == 44 ? {29'h0, debug_mode_pin_i, 3'h0} : 0);
    rd(8'h30, 33'h1_0000_0000);
    v = xs(seed);
    // data first, then direction; lane 0 off is ignored
    wr(8'h04, v);
    wb(8'h04, ~v, 1, 4'h0);
    wr(8'h08, 8'hff);
    rd(8'h04, v[7:0]);
    `CHK(pin_o, v[7:0])
    rd(8'h00, v[7:0]);
    periph_dat_i <= v[15:8];
    periph_oe_i <= 8'hc0;
    periph_own_i <= 8'hf0;
    rd(8'h04, v[7:0]);
    `CHK(pin_oe_o, 8'hcf)
    `CHK(pin_o[7:6], v[15:14])
    wr(8'h08, 0);
    repeat (2) @(posedge clk_i);
    rd(8'h04, {v[15:14], ext[5:0]});
    periph_own_i <= 0;
    ext_en <= 0;
    wr(8'h04, 8'haa);
    wr(8'h08, 8'h0f);
    wr(8'h10, 8'hff);
    wr(8'h14, 8'h30);
    wr(8'h18, 8'h0f);
    wr(8'h0c, 8'hff);
    repeat (2) @(posedge clk_i);
    `CHK({pull_up_o, pull_down_o}, 16'hcf30)
    `CHK(pin_oe_o, 8'h05)
    `CHK(reduced_drive_o & pin_oe_o, 8'h05)
    rd(8'h00, 8'hca);
    wr(8'h18, 0);
    repeat (2) @(posedge clk_i);
    `CHK(pull_up_o, 8'hc0)
    ext_en <= 8'hff;
    ext <= 8'h01;
    wr(8'h08, 0);
    wr(8'h14, 8'h02);
    repeat (8) @(posedge clk_i);
    wr(8'h20, 8'hff);
    pulse(8'h03, 3);
    rd(8'h20, 0);
    pulse(8'h03, 4);
    rd(8'h20, 8'h03);
    `CHK(pin_irq_o, 1'b0)
    wr(8'h1c, 8'h01);
    repeat (2) @(posedge clk_i);
    `CHK(pin_irq_o & wake_o, 1'b1)
    wr(8'h20, 8'h02);
    rd(8'h20, 8'h01);
    stop_mode_i <= 1;
    repeat (3) @(posedge clk_i);
    `CHK(rc_osc_run_o, 1'b0)
    wr(8'h20, 8'h01);
    repeat (3) @(posedge clk_i);
    `CHK({rc_osc_run_o, pin_irq_o}, 2'b10)
    stop_mode_i <= 0;
    irq_pin_n_i <= 0;
    cpu_i_mask_i <= 0;
    nonmaskable_irq_input_pin_n_i <= 0;
    cpu_x_mask_i <= 0;
    repeat (4) @(posedge clk_i);
    `CHK({maskable_irq_o, nonmaskable_irq_o}, 2'b01)
    wr(8'h28, 8'h04);
    repeat (4) @(posedge clk_i);
    `CHK(maskable_irq_o, 1'b1)
    `CHK(expq.size(), 0)
    end_sim;
  end
endmodule
bind gpc_port gpc_port_checker chk (.clk_i, .rst_i, .wb_adr_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .wb_err_o, .pin_o, .pin_oe_o, .pull_up_o, .pull_down_o, .periph_own_i,
  .periph_oe_i, .pin_irq_o, .wake_o, .mode_select_o, .cpu_i_mask_i, .maskable_irq_o,
  .nonmaskable_irq_input_pin_n_i, .cpu_x_mask_i, .nonmaskable_irq_o);

// [gpc_port_checker.sv]
// concurrent checks on the gpio port's top-level ports
// bound to gpc_port from the bench top file, single bus clock
`timescale 1ns/1ns
module gpc_port_checker (
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] wb_adr_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire wb_err_o,
  input wire [7:0] pin_o,
  input wire [7:0] pin_oe_o,
  input wire [7:0] pull_up_o,
  input wire [7:0] pull_down_o,
  input wire [7:0] periph_own_i,
  input wire [7:0] periph_oe_i,
  input wire pin_irq_o,
  input wire wake_o,
  input wire mode_select_o,
  input wire cpu_i_mask_i,
  input wire maskable_irq_o,
  input wire nonmaskable_irq_input_pin_n_i,
  input wire cpu_x_mask_i,
  input wire nonmaskable_irq_o
);
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire [7:0] p_off = periph_own_i & ~periph_oe_i;
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_bus_answer: assert property (req |=> wb_ack_o ^ wb_err_o)
    else $error("no single answer after request");
  a_err_unmapped: assert property (req && wb_adr_i > 8'h2c |=> wb_err_o)
    else $error("unmapped access not refused");
  a_push_no_pull: assert property ((pin_oe_o & pin_o & (pull_up_o | pull_down_o)) == 8'h00)
    else $error("pull on driven output");
  a_pull_exclusive: assert property (((pull_up_o | pin_oe_o) & pull_down_o) == 8'h00)
    else $error("pull-down on output or with pull-up");
  a_irq_wake: assert property (pin_irq_o == wake_o)
    else $error("wake differs from pin request");
  a_mode_hold: assert property (!$past(rst_i) && !$past(rst_i, 2) |-> $stable(mode_select_o))
    else $error("mode changed outside reset");
  a_imask_gate: assert property (cpu_i_mask_i [*3] |-> !maskable_irq_o)
    else $error("maskable request while masked");
  a_nonmaskable_irq_input_level: assert property ((!nonmaskable_irq_input_pin_n_i && !cpu_x_mask_i) [*3] |-> nonmaskable_irq_o)
    else $error("nonmaskable request missing");
  a_periph_off: assert property ((pin_oe_o & p_off & $past(p_off) & 8'hfc) == 8'h00)
    else $error("pin driven against peripheral");
  c_irq: cover property (pin_irq_o);
  c_err: cover property (wb_err_o);
  c_nmi: cover property (nonmaskable_irq_o);
endmodule

// [gpc_regs.vh]
// register offsets, reset values and filter constants for the gpio port block
// assumes a classic wishbone slave with 32-bit data, byte addresses
`ifndef GPC_REGS_VH
`define GPC_REGS_VH

`define GPC_W 8
`define GPC_ADDR_W 8

`define GPC_OFF_PIN_LEVEL 8'h00
`define GPC_OFF_OUT_VALUE 8'h04
`define GPC_OFF_DIRECTION 8'h08
`define GPC_OFF_DRIVE 8'h0C
`define GPC_OFF_PULL_EN 8'h10
`define GPC_OFF_POLARITY 8'h14
`define GPC_OFF_OPEN_DRAIN 8'h18
`define GPC_OFF_IRQ_MASK 8'h1C
`define GPC_OFF_IRQ_FLAG 8'h20
`define GPC_OFF_PWM_REROUTE 8'h24
`define GPC_OFF_PORTE_CTRL 8'h28
`define GPC_OFF_STATUS 8'h2C

`define GPC_RST_BYTE 8'h00
`define GPC_RST_PORTE 8'h00

// portectrl fields
`define GPC_PE_CORE_CLK_BIT 0
`define GPC_PE_BUS_CLK_BIT 1
`define GPC_PE_IRQ_EN_BIT 2
`define GPC_PE_IRQ_EDGE_BIT 3
`define GPC_PE_DIV_LSB 4
`define GPC_PE_DIV_MSB 7

// glitch filter sample counts
`define GPC_FILT_CNT 4
`define GPC_FILT_CNT_W 3

`endif
